// >>> rtl/pcs_supervisor.sv
`timescale 1ns/10ps
module pcs_supervisor
   import pcs_pkg::*;
#(
   parameter int unsigned FILTER_CYC  = DEBOUNCE_CYC,
   parameter int unsigned OFF_CYC     = OFF_HOLD_CYC,
   parameter int unsigned AC_CYC      = AC_OFF_CYC,
   parameter int unsigned PGOOD_CYC   = PGOOD_DELAY_CYC
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        power_on_request_n,
   input  wire pcs_faults_t faults,
   input  wire pcs_module_t modSt,
   input  wire logic        smbClkIn,
   input  wire logic        smbDataIn,
   output logic             smbClkOut,
   output logic             smbClkOe,
   output logic             smbDataOut,
   output logic             smbDataOe,
   output logic             mainRailEn,
   output logic             standby_rail,
   output logic             power_good_out,
   output logic             fault_alert_n,
   output logic             ledRed,
   output logic             statusTtlOut,
   output logic             statusTtlOe
);

   logic             onReqClean;
   pcs_state_t       state_ff;
   pcs_state_t       nxt_state;
   logic [CNT_W-1:0] offCnt_ff;
   logic [CNT_W-1:0] nxt_offCnt;
   logic [CNT_W-1:0] acCnt_ff;
   logic [CNT_W-1:0] nxt_acCnt;
   logic [CNT_W-1:0] pgCnt_ff;
   logic [CNT_W-1:0] nxt_pgCnt;
   logic             offSeen_ff;
   logic             nxt_offSeen;
   logic             mainEn_ff;
   logic             nxt_mainEn;
   logic             sbEn_ff;
   logic             nxt_sbEn;
   logic             pgood_ff;
   logic             nxt_pgood;
   logic             alertN_ff;
   logic             nxt_alertN;
   logic             red_ff;
   logic             nxt_red;
   logic             ttlLow_ff;
   logic             nxt_ttlLow;
   logic             mainTrip;
   logic             alertEvent;

   pcs_debounce #(
      .FILTER_CYC (FILTER_CYC)
   ) u_onreq (
      .clk      (clk),
      .rst_n    (rst_n),
      .rawIn    (power_on_request_n),
      .cleanOut (onReqClean)
   );

   // Pull-up on the pin makes an open input arrive here as high, i.e. off
   assign mainTrip   = faults.overcurrentTrip | faults.overvoltageTrip;
   assign alertEvent = mainTrip | faults.standbyOvercurrent | faults.standbyShort
                     | faults.overTemp | faults.warning | faults.envLimit
                     | modSt.moduleFailed;

   // Main sequencer
   always_comb begin
      nxt_state   = state_ff;
      nxt_offCnt  = '0;
      nxt_acCnt   = '0;
      nxt_offSeen = offSeen_ff;
      nxt_pgCnt   = '0;
      unique case (state_ff)
         PCS_OFF: begin
            if (!onReqClean && modSt.acPresent && !mainTrip) begin
               nxt_state = PCS_RAMP;
            end
         end
         PCS_RAMP: begin
            if (mainTrip) begin
               nxt_state = PCS_LATCHED;
            end else if (onReqClean || !modSt.acPresent) begin
               nxt_state = PCS_OFF;
            end else if (modSt.mainInReg) begin
               if (pgCnt_ff >= CNT_W'(PGOOD_CYC - 1)) begin
                  nxt_state = PCS_ON;
               end else begin
                  nxt_pgCnt = pgCnt_ff + CNT_W'(1);
               end
            end
         end
         PCS_ON: begin
            if (mainTrip) begin
               nxt_state = PCS_LATCHED;
            end else if (onReqClean || !modSt.acPresent) begin
               nxt_state = PCS_OFF;
            end else if (!modSt.mainInReg) begin
               nxt_state = PCS_RAMP;
            end
         end
         PCS_LATCHED: begin
            // Restart only after an off cycle; on-request must return low after it
            if (!modSt.acPresent) begin
               if (acCnt_ff >= CNT_W'(AC_CYC - 1)) begin
                  nxt_state = PCS_OFF;
               end else begin
                  nxt_acCnt = acCnt_ff + CNT_W'(1);
               end
            end
            if (onReqClean) begin
               if (offCnt_ff >= CNT_W'(OFF_CYC - 1)) begin
                  nxt_offSeen = 1'b1;
                  nxt_offCnt  = offCnt_ff;
               end else begin
                  nxt_offCnt = offCnt_ff + CNT_W'(1);
               end
            end else if (offSeen_ff && !mainTrip) begin
               nxt_state = PCS_OFF;
            end
            if (nxt_state == PCS_OFF) begin
               nxt_offSeen = 1'b0;
            end
         end
      endcase
   end

   // Output levels
   always_comb begin
      nxt_mainEn = (nxt_state == PCS_RAMP) || (nxt_state == PCS_ON);
      // Standby follows AC presence and its own faults only, and recovers on its own
      nxt_sbEn   = modSt.acPresent && !faults.standbyShort
                 && !faults.standbyOvercurrent;
      nxt_pgood  = (nxt_state == PCS_ON) && modSt.mainInReg;
      nxt_alertN = !alertEvent;
      nxt_red    = alertEvent;
      nxt_ttlLow = !modSt.moduleDummy
                 && (!modSt.acPresent || !modSt.modulePresent || modSt.moduleFailed
                     || state_ff == PCS_LATCHED || !nxt_pgood);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff   <= PCS_OFF;
         offCnt_ff  <= '0;
         acCnt_ff   <= '0;
         pgCnt_ff   <= '0;
         offSeen_ff <= 1'b0;
         mainEn_ff  <= 1'b0;
         sbEn_ff    <= 1'b0;
         pgood_ff   <= 1'b0;
         alertN_ff  <= 1'b1;
         red_ff     <= 1'b0;
         ttlLow_ff  <= 1'b1;
      end else begin
         state_ff   <= nxt_state;
         offCnt_ff  <= nxt_offCnt;
         acCnt_ff   <= nxt_acCnt;
         pgCnt_ff   <= nxt_pgCnt;
         offSeen_ff <= nxt_offSeen;
         mainEn_ff  <= nxt_mainEn;
         sbEn_ff    <= nxt_sbEn;
         pgood_ff   <= nxt_pgood;
         alertN_ff  <= nxt_alertN;
         red_ff     <= nxt_red;
         ttlLow_ff  <= nxt_ttlLow;
      end
   end

   // Management link pins are released; the transaction engine lives elsewhere
   logic smbIdle_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         smbIdle_ff <= 1'b0;
      end else begin
         smbIdle_ff <= smbClkIn & smbDataIn;
      end
   end

   assign smbClkOut      = 1'b0;
   assign smbClkOe       = 1'b0;
   assign smbDataOut     = 1'b0;
   assign smbDataOe      = 1'b0;
   assign mainRailEn     = mainEn_ff;
   assign standby_rail   = sbEn_ff;
   assign power_good_out = pgood_ff;
   assign fault_alert_n  = alertN_ff;
   assign ledRed         = red_ff;
   assign statusTtlOut   = 1'b0;
   assign statusTtlOe    = ttlLow_ff;

endmodule

// >>> rtl/pcs_pkg.sv
package pcs_pkg;

   // Clock rate and timing figures
   localparam int unsigned CLK_HZ           = 40_000_000;
   localparam int unsigned DEBOUNCE_US      = 1000;
   localparam int unsigned DEBOUNCE_CYC     = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
   localparam int unsigned OFF_HOLD_MS      = 1000;
   localparam int unsigned OFF_HOLD_CYC     = (CLK_HZ / 1000) * OFF_HOLD_MS;
   localparam int unsigned AC_OFF_MS        = 15000;
   localparam int unsigned AC_OFF_CYC       = (CLK_HZ / 1000) * AC_OFF_MS;
   localparam int unsigned PGOOD_DELAY_MS   = 100;
   localparam int unsigned PGOOD_DELAY_CYC  = (CLK_HZ / 1000) * PGOOD_DELAY_MS;
   localparam int unsigned CNT_W            = 30;

   // Main sequencer states, Gray along off -> ramp -> on -> latched
   typedef enum logic [1:0] {
      PCS_OFF     = 2'b00,
      PCS_RAMP    = 2'b01,
      PCS_ON      = 2'b11,
      PCS_LATCHED = 2'b10
   } pcs_state_t;

   // Fault and status inputs from the analog monitors
   typedef struct packed {
      logic overcurrentTrip;
      logic overvoltageTrip;
      logic standbyOvercurrent;
      logic standbyShort;
      logic overTemp;
      logic warning;
      logic envLimit;
   } pcs_faults_t;

   typedef struct packed {
      logic acPresent;
      logic modulePresent;
      logic moduleDummy;
      logic moduleFailed;
      logic mainInReg;
   } pcs_module_t;

endpackage

// >>> rtl/pcs_debounce.sv
`timescale 1ns/10ps
module pcs_debounce
   import pcs_pkg::*;
#(
   parameter int unsigned FILTER_CYC = DEBOUNCE_CYC
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic rawIn,
   output logic      cleanOut
);

   logic             sync1_ff;
   logic             sync2_ff;
   logic             clean_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             nxt_clean;
   logic [CNT_W-1:0] nxt_cnt;

   // Filter needs a stable level for the full period before it moves
   always_comb begin
      nxt_clean = clean_ff;
      nxt_cnt   = '0;
      if (sync2_ff != clean_ff) begin
         if (cnt_ff >= CNT_W'(FILTER_CYC - 1)) begin
            nxt_clean = sync2_ff;
         end else begin
            nxt_cnt = cnt_ff + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
         clean_ff <= 1'b1;
         cnt_ff   <= '0;
      end else begin
         sync1_ff <= rawIn;
         sync2_ff <= sync1_ff;
         clean_ff <= nxt_clean;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign cleanOut = clean_ff;

endmodule

// >>> verification/pcs_supervisor_monitor.sv
`timescale 1ns/10ps
module pcs_supervisor_monitor
   import pcs_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        power_on_request_n,
   input wire pcs_faults_t faults,
   input wire logic        smbClkOe,
   input wire logic        smbDataOe,
   input wire logic        mainRailEn,
   input wire logic        standby_rail,
   input wire logic        power_good_out,
   input wire logic        fault_alert_n,
   input wire logic        ledRed,
   input wire logic        statusTtlOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Request released long enough to pass the filter
   sequence s_req_off;
      power_on_request_n [*8];
   endsequence
   a_req_off_main: assert property (s_req_off |-> ##2 !mainRailEn)
      else $error("main rail on while request off");
   a_pgood_needs_main: assert property (power_good_out |-> mainRailEn)
      else $error("power good without main rail");
   a_warn_alert: assert property (faults[2:0] != 3'h0 |=> !fault_alert_n)
      else $error("event without alert");
   a_alert_led: assert property (fault_alert_n != ledRed)
      else $error("alert and red led differ");
   a_smb_released: assert property (!smbClkOe && !smbDataOe)
      else $error("bus line driven");
   a_pgood_status: assert property ($rose(power_good_out) |-> !statusTtlOe)
      else $error("status low with power good");
   a_trip_standby: assert property ((faults[6:5] != 2'h0) && standby_rail
      && faults[4:3] == 2'h0 |=> standby_rail)
      else $error("standby dropped on main trip");
   a_ocp_latch: assert property (faults.overcurrentTrip |-> ##2 (!mainRailEn) [*8])
      else $error("over-current did not latch off");
   a_sby_short: assert property (faults.standbyShort |=> !standby_rail)
      else $error("standby on during short");
   a_ovp_latch: assert property (faults.overvoltageTrip |-> ##2 (!mainRailEn) [*8])
      else $error("over-voltage did not latch off");
endmodule

// >>> verification/pcs_board_model.sv
`timescale 1ns/10ps
module pcs_board_model (
   input  wire logic pullOnReq,
   input  wire logic clkOut,
   input  wire logic clkOe,
   input  wire logic datOut,
   input  wire logic datOe,
   output logic      onReqN,
   output logic      clkLine,
   output logic      datLine
);
   // Open collector with pull-up: released means off
   assign onReqN  = !pullOnReq;
   // Bus lines float high through pull-ups
   assign clkLine = clkOe ? clkOut : 1'b1;
   assign datLine = datOe ? datOut : 1'b1;
endmodule

// >>> verification/tb_pcs_supervisor.sv
`timescale 1ns/10ps
module tb_pcs_supervisor;
   import pcs_pkg::*;
   logic        clk, rst_n, pullOnReq, power_on_request_n, smbClkIn, smbDataIn;
   logic        smbClkOut, smbClkOe, smbDataOut, smbDataOe, mainRailEn, standby_rail;
   logic        power_good_out, fault_alert_n, ledRed, statusTtlOut, statusTtlOe;
   pcs_faults_t faults;
   pcs_module_t modSt;
   int          failures = 0;
   int          total_checks = 0;
   pcs_board_model i_brd (.pullOnReq(pullOnReq), .clkOut(smbClkOut), .clkOe(smbClkOe),
      .datOut(smbDataOut), .datOe(smbDataOe), .onReqN(power_on_request_n),
      .clkLine(smbClkIn), .datLine(smbDataIn));
   pcs_supervisor #(.FILTER_CYC(4), .OFF_CYC(20), .AC_CYC(30), .PGOOD_CYC(5)) i_dut (.*);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_on();
      for (int i = 0; i < 80 && mainRailEn !== 1'b1; i++) tick(1);
      chk(mainRailEn, 1'b1, "main rail off");
      tick(10);
   endtask
   task automatic t_glitch();
      pullOnReq = 1'b1;
      tick(2);
      pullOnReq = 1'b0;
      tick(20);
      chk(mainRailEn, 1'b0, "glitch took effect");
   endtask
   task automatic t_on();
      pullOnReq = 1'b1;
      wait_on();
      chk(power_good_out, 1'b1, "no power good");
      chk(statusTtlOe, 1'b0, "status low");
      chk(fault_alert_n, 1'b1, "alert when ok");
      chk(smbClkIn & smbDataIn, 1'b1, "bus held");
   endtask
   task automatic t_trip(input logic overvoltage_trip);
      faults = pcs_faults_t'(overvoltage_trip ? 7'h20 : 7'h40);
      tick(3);
      faults = '0;
      chk(mainRailEn, 1'b0, "rail on after trip");
      chk(power_good_out, 1'b0, "power good after trip");
      chk(ledRed, 1'b1, "no red after trip");
      chk(statusTtlOe, 1'b1, "status high after trip");
      chk(standby_rail, 1'b1, "standby lost");
      tick(40);
      chk(mainRailEn, 1'b0, "latch released");
      modSt.acPresent = !overvoltage_trip;
      pullOnReq = overvoltage_trip;
      tick(45);
      modSt.acPresent = 1'b1;
      pullOnReq = 1'b1;
      wait_on();
   endtask
   task automatic t_sby();
      faults.standbyShort = 1'b1;
      tick(2);
      chk(standby_rail, 1'b0, "standby on in short");
      faults.standbyShort = 1'b0;
      tick(2);
      chk(standby_rail, 1'b1, "standby not back");
   endtask
   task automatic t_status();
      modSt.moduleFailed = 1'b1;
      tick(2);
      chk(statusTtlOe, 1'b1, "failure hidden");
      modSt = pcs_module_t'(5'h11);
      tick(2);
      chk(statusTtlOe, 1'b1, "absent module hidden");
      modSt = pcs_module_t'(5'h1d);
      tick(2);
      chk(statusTtlOe, 1'b0, "dummy not released");
   endtask
   task automatic t_warn();
      for (int i = 0; i < 3; i++) begin
         faults = pcs_faults_t'(7'h01 << i);
         tick(2);
         chk(fault_alert_n, 1'b0, "no alert");
         chk(ledRed, 1'b1, "no red");
         faults = '0;
         tick(2);
         chk(fault_alert_n, 1'b1, "alert stuck");
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      pullOnReq = 1'b0;
      faults = '0;
      modSt = pcs_module_t'(5'h19);
      tick(6);
      chk(mainRailEn, 1'b0, "rail on in reset");
      chk(statusTtlOe, 1'b1, "status in reset");
      rst_n = 1'b1;
      t_glitch();
      t_on();
      t_trip(1'b0);
      t_trip(1'b1);
      t_sby();
      t_status();
      t_warn();
      print_verdict();
   end
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      print_verdict();
   end
endmodule
bind pcs_supervisor pcs_supervisor_monitor i_mon (.*);
